// ===== design/cnm_pkg.sv
// Constants, register map and state type of the configuration memory transfer controller.
// Assumes a decoded byte-wide register port from the serial control port and a 20 MHz clock.
package cnm_pkg;
    localparam logic [11:0] ADDR_PIN_CFG = 12'h232;
    localparam logic [11:0] ADDR_COMMIT = 12'h234;
    localparam logic [11:0] ADDR_SEG_FIRST = 12'ha00;
    localparam logic [11:0] ADDR_SEG_LAST = 12'ha16;
    localparam logic [11:0] ADDR_PENDING = 12'hb00;
    localparam logic [11:0] ADDR_DATA_ERR = 12'hb01;
    localparam logic [11:0] ADDR_CTRL1 = 12'hb02;
    localparam logic [11:0] ADDR_STORE = 12'hb03;
    localparam int BIT_PIN_SEL = 4;
    localparam int BIT_COMMIT = 0;
    localparam int BIT_PENDING = 0;
    localparam int BIT_DATA_ERR = 0;
    localparam int BIT_WR_EN = 0;
    localparam int BIT_RELOAD = 1;
    localparam int BIT_STORE = 0;
    localparam int OP_FLAG_BIT = 7;
    localparam int SEG_COUNT = 23;
    localparam logic [4:0] SEG_COUNT_W = 5'h17;
    localparam logic [7:0] OP_COMMIT = 8'h80;
    localparam logic [7:0] OP_TERMINATOR = 8'hff;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
    localparam logic WR_EN_RST = 1'b0;
    localparam logic BOOT_SEL_RST = 1'b1;
    // Header byte holds count minus one; five 128-byte segments cover 0x000 to 0x27f.
    localparam logic [7:0] SEG_DEFAULT [SEG_COUNT] = '{
        8'h7f, 8'h00, 8'h00, 8'h7f, 8'h00, 8'h80, 8'h7f, 8'h01, 8'h00,
        8'h7f, 8'h01, 8'h80, 8'h7f, 8'h02, 8'h00, OP_COMMIT,
        OP_TERMINATOR, OP_TERMINATOR, OP_TERMINATOR, OP_TERMINATOR,
        OP_TERMINATOR, OP_TERMINATOR, OP_TERMINATOR};
    typedef enum logic [2:0] {
        S_IDLE,
        S_ENTRY,
        S_ADDR_HI,
        S_ADDR_LO,
        S_DATA,
        S_COMMIT,
        S_DRAIN
    } cnm_state_e;
endpackage : cnm_pkg

// ===== design/cnm_nvm_xfer_ctrl.sv
// Transfer controller between the register buffer bank and the configuration memory, with its FIFO.
// Assumes buffer bank reads are combinational and the memory answers each request with a one-cycle ack.
`timescale 1ns/1ns
`default_nettype none

module cnm_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input wire logic clock_i, // System clock.
    input wire logic rst_n_i, // Asynchronous reset, active low.
    input wire logic in_valid_i, // Write side valid.
    output logic in_ready_o, // Write side ready.
    input wire logic [WIDTH-1:0] in_data_i, // Write side data.
    output logic out_valid_o, // Read side valid.
    input wire logic out_ready_i, // Read side ready.
    output logic [WIDTH-1:0] out_data_o // Read side data.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_idx;
    logic [AW-1:0] rd_idx;
    logic [AW:0] count;
    logic do_push;
    logic do_pop;

    assign in_ready_o = count != (AW+1)'(DEPTH);
    assign out_valid_o = count != '0;
    assign out_data_o = mem[rd_idx];
    assign do_push = in_valid_i && in_ready_o;
    assign do_pop = out_valid_o && out_ready_i;

    always_ff @(posedge clock_i)
    begin
        if (do_push)
        begin
            mem[wr_idx] <= in_data_i;
        end
    end

    // Index wrap assumes DEPTH is a power of two.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_idx <= '0;
            rd_idx <= '0;
            count <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_idx <= wr_idx + 1'b1;
            end
            if (do_pop)
            begin
                rd_idx <= rd_idx + 1'b1;
            end
            if (do_push && !do_pop)
            begin
                count <= count + 1'b1;
            end
            else if (do_pop && !do_push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : cnm_fifo

module cnm_nvm_xfer_ctrl #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clock_i, // 20 MHz clock.
    input wire logic rst_n_i, // Asynchronous reset, active low.
    input wire logic [11:0] reg_addr_i, // Register address.
    input wire logic reg_wr_i, // Register write strobe.
    input wire logic [7:0] reg_wdata_i, // Register write data.
    input wire logic reg_rd_i, // Register read strobe.
    output logic [7:0] reg_rdata_o, // Read data, one cycle after strobe.
    input wire logic boot_sel_i, // Boot select pin, asynchronous.
    output logic soft_reset_o, // Device soft reset pulse.
    output logic commit_o, // Buffer to active copy pulse.
    output logic [15:0] buf_addr_o, // Buffer bank address.
    input wire logic [7:0] buf_rdata_i, // Buffer bank read data.
    output logic buf_wr_o, // Buffer bank write strobe.
    output logic [7:0] buf_wdata_o, // Buffer bank write data.
    output logic nvm_req_o, // Memory request, held to ack.
    output logic nvm_we_o, // Memory request is a write.
    output logic [15:0] nvm_addr_o, // Memory byte address.
    output logic [7:0] nvm_wdata_o, // Memory write data.
    input wire logic nvm_ack_i, // Memory ack, one cycle.
    input wire logic [7:0] nvm_rdata_i, // Memory read data at ack.
    input wire logic nvm_err_i, // Memory flags bad read data at ack.
    output logic first_status_output_pin_o // Status pin mirror.
);
    localparam int FW = 24;
    logic [7:0] seg [cnm_pkg::SEG_COUNT];
    cnm_pkg::cnm_state_e st;
    logic xfer_load;
    logic wr_en;
    logic reload_bit;
    logic store_bit;
    logic pin_sel;
    logic data_err;
    logic [4:0] idx;
    logic [7:0] remaining;
    logic [15:0] cur_addr;
    logic [15:0] nvm_ptr;
    logic boot_s1;
    logic boot_s2;
    logic boot_s3;
    logic boot_sel_q;
    logic f_in_valid;
    logic f_in_ready;
    logic f_out_valid;
    logic f_out_ready;
    logic [FW-1:0] f_in_data;
    logic [FW-1:0] f_out_data;
    logic [7:0] entry;
    logic [11:0] seg_off;
    logic busy;
    logic push;
    logic load_req;
    logic seg_end;
    logic wr_seg;
    logic wr_ctrl1;
    logic wr_store;
    logic wr_commit;
    logic start_load;
    logic start_store;
    logic done;

    assign busy = st != cnm_pkg::S_IDLE;
    assign seg_end = idx >= cnm_pkg::SEG_COUNT_W;
    assign entry = seg_end ? cnm_pkg::OP_TERMINATOR : seg[idx];
    assign seg_off = reg_addr_i - cnm_pkg::ADDR_SEG_FIRST;
    assign wr_seg = reg_wr_i && reg_addr_i >= cnm_pkg::ADDR_SEG_FIRST && reg_addr_i <= cnm_pkg::ADDR_SEG_LAST;
    assign wr_ctrl1 = reg_wr_i && reg_addr_i == cnm_pkg::ADDR_CTRL1;
    assign wr_store = reg_wr_i && reg_addr_i == cnm_pkg::ADDR_STORE;
    assign wr_commit = reg_wr_i && reg_addr_i == cnm_pkg::ADDR_COMMIT;
    // A start while a transfer runs is dropped rather than queued.
    assign start_load = wr_ctrl1 && reg_wdata_i[cnm_pkg::BIT_RELOAD] && !boot_sel_q && !busy;
    assign start_store = wr_store && reg_wdata_i[cnm_pkg::BIT_STORE] && wr_en && !busy;
    assign done = st == cnm_pkg::S_DRAIN && !f_out_valid;

    // Each FIFO word is {address, byte}: memory address on a store, buffer address on a load.
    assign load_req = xfer_load && st == cnm_pkg::S_DATA && f_in_ready;
    assign f_in_valid = xfer_load ? (load_req && nvm_ack_i) : (st == cnm_pkg::S_DATA);
    assign f_in_data = xfer_load ? {cur_addr, nvm_rdata_i} : {nvm_ptr, buf_rdata_i};
    assign push = f_in_valid && f_in_ready;
    assign f_out_ready = xfer_load ? 1'b1 : nvm_ack_i;
    assign buf_addr_o = xfer_load ? f_out_data[FW-1:8] : cur_addr;
    assign buf_wr_o = xfer_load && f_out_valid;
    assign buf_wdata_o = f_out_data[7:0];
    assign nvm_req_o = xfer_load ? load_req : f_out_valid;
    assign nvm_we_o = !xfer_load && f_out_valid;
    assign nvm_addr_o = xfer_load ? nvm_ptr : f_out_data[FW-1:8];
    assign nvm_wdata_o = f_out_data[7:0];

    cnm_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(f_in_valid),
        .in_ready_o(f_in_ready),
        .in_data_i(f_in_data),
        .out_valid_o(f_out_valid),
        .out_ready_i(f_out_ready),
        .out_data_o(f_out_data)
    );

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            boot_s1 <= cnm_pkg::BOOT_SEL_RST;
            boot_s2 <= cnm_pkg::BOOT_SEL_RST;
            boot_s3 <= cnm_pkg::BOOT_SEL_RST;
            boot_sel_q <= cnm_pkg::BOOT_SEL_RST;
        end
        else
        begin
            boot_s1 <= boot_sel_i;
            boot_s2 <= boot_s1;
            boot_s3 <= boot_s2;
            if (boot_s2 == boot_s3)
            begin
                boot_sel_q <= boot_s3;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            seg <= cnm_pkg::SEG_DEFAULT;
        end
        else if (wr_seg)
        begin
            seg[seg_off[4:0]] <= reg_wdata_i;
        end
    end

    // Segment walker: header byte, address high, address low, then the data bytes.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st <= cnm_pkg::S_IDLE;
            idx <= '0;
            remaining <= '0;
            cur_addr <= '0;
            nvm_ptr <= '0;
            xfer_load <= 1'b0;
        end
        else
        begin
            case (st)
                cnm_pkg::S_IDLE:
                begin
                    if (start_load || start_store)
                    begin
                        st <= cnm_pkg::S_ENTRY;
                        idx <= '0;
                        nvm_ptr <= '0;
                        xfer_load <= start_load;
                    end
                end
                cnm_pkg::S_ENTRY:
                begin
                    if (entry == cnm_pkg::OP_TERMINATOR)
                    begin
                        st <= cnm_pkg::S_DRAIN;
                    end
                    else if (entry == cnm_pkg::OP_COMMIT)
                    begin
                        st <= cnm_pkg::S_COMMIT;
                    end
                    else if (entry[cnm_pkg::OP_FLAG_BIT])
                    begin
                        idx <= idx + 1'b1;
                    end
                    else
                    begin
                        remaining <= {1'b0, entry[6:0]} + 8'h01;
                        idx <= idx + 1'b1;
                        st <= cnm_pkg::S_ADDR_HI;
                    end
                end
                cnm_pkg::S_ADDR_HI:
                begin
                    cur_addr[15:8] <= entry;
                    idx <= idx + 1'b1;
                    st <= seg_end ? cnm_pkg::S_DRAIN : cnm_pkg::S_ADDR_LO;
                end
                cnm_pkg::S_ADDR_LO:
                begin
                    cur_addr[7:0] <= entry;
                    idx <= idx + 1'b1;
                    st <= seg_end ? cnm_pkg::S_DRAIN : cnm_pkg::S_DATA;
                end
                cnm_pkg::S_DATA:
                begin
                    if (push)
                    begin
                        cur_addr <= cur_addr + 16'h0001;
                        nvm_ptr <= nvm_ptr + 16'h0001;
                        remaining <= remaining - 8'h01;
                        if (remaining == 8'h01)
                        begin
                            st <= cnm_pkg::S_ENTRY;
                        end
                    end
                end
                cnm_pkg::S_COMMIT:
                begin
                    // A load commits only once every queued byte is in the buffer bank.
                    if (!xfer_load || !f_out_valid)
                    begin
                        idx <= idx + 1'b1;
                        st <= cnm_pkg::S_ENTRY;
                    end
                end
                cnm_pkg::S_DRAIN:
                begin
                    if (!f_out_valid)
                    begin
                        st <= cnm_pkg::S_IDLE;
                    end
                end
                default:
                begin
                    st <= cnm_pkg::S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            commit_o <= 1'b0;
            soft_reset_o <= 1'b0;
        end
        else
        begin
            commit_o <= (wr_commit && reg_wdata_i[cnm_pkg::BIT_COMMIT])
                || (st == cnm_pkg::S_COMMIT && xfer_load && !f_out_valid);
            soft_reset_o <= start_load;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_en <= cnm_pkg::WR_EN_RST;
            pin_sel <= 1'b0;
        end
        else
        begin
            if (wr_ctrl1)
            begin
                wr_en <= reg_wdata_i[cnm_pkg::BIT_WR_EN];
            end
            if (reg_wr_i && reg_addr_i == cnm_pkg::ADDR_PIN_CFG)
            begin
                pin_sel <= reg_wdata_i[cnm_pkg::BIT_PIN_SEL];
            end
        end
    end

    // Trigger bits cannot be set while busy, so a set never meets the clearing edge.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            store_bit <= 1'b0;
            reload_bit <= 1'b0;
        end
        else
        begin
            if (start_store)
            begin
                store_bit <= 1'b1;
            end
            else if (done)
            begin
                store_bit <= 1'b0;
            end
            if (start_load)
            begin
                reload_bit <= 1'b1;
            end
            else if (done)
            begin
                reload_bit <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            data_err <= 1'b0;
            first_status_output_pin_o <= 1'b0;
        end
        else
        begin
            if (start_load)
            begin
                data_err <= 1'b0;
            end
            else if (load_req && nvm_ack_i && nvm_err_i)
            begin
                data_err <= 1'b1;
            end
            first_status_output_pin_o <= pin_sel && busy;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            reg_rdata_o <= cnm_pkg::RD_UNMAPPED;
        end
        else if (reg_rd_i)
        begin
            reg_rdata_o <= cnm_pkg::RD_UNMAPPED;
            if (reg_addr_i >= cnm_pkg::ADDR_SEG_FIRST && reg_addr_i <= cnm_pkg::ADDR_SEG_LAST)
            begin
                reg_rdata_o <= seg[seg_off[4:0]];
            end
            case (reg_addr_i)
                cnm_pkg::ADDR_PIN_CFG: reg_rdata_o[cnm_pkg::BIT_PIN_SEL] <= pin_sel;
                cnm_pkg::ADDR_PENDING: reg_rdata_o[cnm_pkg::BIT_PENDING] <= busy;
                cnm_pkg::ADDR_DATA_ERR: reg_rdata_o[cnm_pkg::BIT_DATA_ERR] <= data_err;
                cnm_pkg::ADDR_CTRL1:
                begin
                    reg_rdata_o[cnm_pkg::BIT_WR_EN] <= wr_en;
                    reg_rdata_o[cnm_pkg::BIT_RELOAD] <= reload_bit;
                end
                cnm_pkg::ADDR_STORE: reg_rdata_o[cnm_pkg::BIT_STORE] <= store_bit;
                default: ;
            endcase
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_seg_walk;
        st == cnm_pkg::S_ADDR_HI ##1 st == cnm_pkg::S_ADDR_LO ##1 st == cnm_pkg::S_DATA;
    endsequence

    property p_seg_header;
        st == cnm_pkg::S_ENTRY && !entry[cnm_pkg::OP_FLAG_BIT] && idx < 5'h15 |=> s_seg_walk;
    endproperty
    a_seg_header: assert property (p_seg_header) else $error("segment header not walked");

    property p_terminator;
        st == cnm_pkg::S_ENTRY && entry == cnm_pkg::OP_TERMINATOR |=> st == cnm_pkg::S_DRAIN;
    endproperty
    a_terminator: assert property (p_terminator) else $error("terminator not honoured");

    property p_pending_read;
        reg_rd_i && reg_addr_i == cnm_pkg::ADDR_PENDING |=> reg_rdata_o == {7'h00, $past(busy)};
    endproperty
    a_pending_read: assert property (p_pending_read) else $error("pending bit wrong");

    property p_pin_mirror;
        ##1 first_status_output_pin_o == $past(pin_sel && busy);
    endproperty
    a_pin_mirror: assert property (p_pin_mirror) else $error("status pin mismatch");

    // The pin and the pending bit both lag busy by one edge, so with the pin selected they must agree.
    property p_pin_matches_bit;
        reg_rd_i && reg_addr_i == cnm_pkg::ADDR_PENDING && pin_sel
            |=> first_status_output_pin_o == reg_rdata_o[cnm_pkg::BIT_PENDING];
    endproperty
    a_pin_matches_bit: assert property (p_pin_matches_bit) else $error("status pin differs from pending bit");

    property p_data_err;
        load_req && nvm_ack_i && nvm_err_i |=> data_err ##0 busy;
    endproperty
    a_data_err: assert property (p_data_err) else $error("data error not flagged");

    property p_reload;
        start_load |=> soft_reset_o && xfer_load && reload_bit ##1 !soft_reset_o;
    endproperty
    a_reload: assert property (p_reload) else $error("soft reload not started");

    property p_protect;
        wr_store && reg_wdata_i[cnm_pkg::BIT_STORE] && !wr_en && !busy |=> !busy && !store_bit;
    endproperty
    a_protect: assert property (p_protect) else $error("protected store started");

    property p_store_start;
        start_store |=> st == cnm_pkg::S_ENTRY && !xfer_load && store_bit;
    endproperty
    a_store_start: assert property (p_store_start) else $error("store not started");

    property p_store_clear;
        done |=> !store_bit && !busy;
    endproperty
    a_store_clear: assert property (p_store_clear) else $error("store bit not cleared");

    property p_commit;
        wr_commit && reg_wdata_i[cnm_pkg::BIT_COMMIT] |=> commit_o;
    endproperty
    a_commit: assert property (p_commit) else $error("commit pulse missing");
endmodule : cnm_nvm_xfer_ctrl

`default_nettype wire

// ===== dv/cnm_far_model.sv
// Far-side model: configuration memory with a one-cycle ack, and the buffer register bank.
// Assumes the controller holds each memory request until ack and reads the bank combinationally.
`timescale 1ns/1ns
`default_nettype none

module cnm_far_model (
    input wire logic clock_i, // Clock.
    input wire logic slow_i, // Stretch the ack latency.
    input wire logic err_inj_i, // Flag read data as bad.
    input wire logic nvm_req_i, // Memory request.
    input wire logic nvm_we_i, // Request is a write.
    input wire logic [15:0] nvm_addr_i, // Memory byte address.
    input wire logic [7:0] nvm_wdata_i, // Memory write data.
    output logic nvm_ack_o, // One-cycle ack.
    output logic [7:0] nvm_rdata_o, // Read data with ack.
    output logic nvm_err_o, // Bad data flag with ack.
    input wire logic [15:0] buf_addr_i, // Bank address.
    output logic [7:0] buf_rdata_o, // Bank read data.
    input wire logic buf_wr_i, // Bank write strobe.
    input wire logic [7:0] buf_wdata_i // Bank write data.
);
    logic [7:0] mem [1024];
    logic [7:0] bank [1024];
    logic [2:0] wait_cnt = 3'h0;

    initial
    begin
        nvm_ack_o = 1'b0;
        nvm_rdata_o = 8'h00;
        nvm_err_o = 1'b0;
        for (int i = 0; i < 1024; i++)
        begin
            mem[i] = 8'h00;
            bank[i] = 8'(i) ^ 8'h5a;
        end
    end

    // Outside an ack the data lines toggle, so a controller that samples late sees garbage.
    always @(posedge clock_i)
    begin
        nvm_ack_o <= 1'b0;
        nvm_rdata_o <= ~nvm_rdata_o;
        nvm_err_o <= ~nvm_err_o;
        wait_cnt <= 3'h0;
        if (nvm_req_i && nvm_ack_o && nvm_we_i)
            mem[nvm_addr_i[9:0]] <= nvm_wdata_i;
        if (nvm_req_i && !nvm_ack_o)
        begin
            wait_cnt <= wait_cnt + 3'h1;
            if (wait_cnt >= (slow_i ? 3'h3 : 3'h0))
            begin
                nvm_ack_o <= 1'b1;
                wait_cnt <= 3'h0;
                nvm_rdata_o <= mem[nvm_addr_i[9:0]];
                nvm_err_o <= err_inj_i;
            end
        end
        if (buf_wr_i)
            bank[buf_addr_i[9:0]] <= buf_wdata_i;
    end

    assign buf_rdata_o = bank[buf_addr_i[9:0]];
endmodule : cnm_far_model

`default_nettype wire

// ===== dv/cnm_nvm_xfer_ctrl_bench.sv
// Testbench for the configuration memory transfer controller: registers, store, reload.
// Assumes the design package, the design and the far-side model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module cnm_nvm_xfer_ctrl_bench;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic boot_sel = 1'b1;
    logic slow = 1'b0;
    logic err_inj = 1'b0;
    wire logic soft_reset, commit, buf_wr, nvm_req, nvm_we, nvm_ack, nvm_err, status_pin;
    wire logic [15:0] buf_addr, nvm_addr;
    wire logic [7:0] buf_rdata, buf_wdata, nvm_wdata, nvm_rdata;
    int mismatches = 0;
    int checks = 0;
    int n_reset = 0;
    int n_commit = 0;
    logic [7:0] val;
    logic [11:0] ra [8] = '{12'hb00, 12'hb01, 12'hb02, 12'hb03, 12'ha00, 12'ha0f, 12'ha16, 12'h100};
    logic [7:0] re [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h7f, 8'h80, 8'hff, 8'h00};
    logic [7:0] seg [5] = '{8'h81, 8'h01, 8'h00, 8'h10, 8'hff};

    always #25 clock_i = ~clock_i;

    cnm_nvm_xfer_ctrl u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
        .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .boot_sel_i(boot_sel),
        .soft_reset_o(soft_reset), .commit_o(commit), .buf_addr_o(buf_addr), .buf_rdata_i(buf_rdata),
        .buf_wr_o(buf_wr), .buf_wdata_o(buf_wdata), .nvm_req_o(nvm_req), .nvm_we_o(nvm_we),
        .nvm_addr_o(nvm_addr), .nvm_wdata_o(nvm_wdata), .nvm_ack_i(nvm_ack), .nvm_rdata_i(nvm_rdata),
        .nvm_err_i(nvm_err), .first_status_output_pin_o(status_pin));

    cnm_far_model u_far (.clock_i(clock_i), .slow_i(slow), .err_inj_i(err_inj), .nvm_req_i(nvm_req),
        .nvm_we_i(nvm_we), .nvm_addr_i(nvm_addr), .nvm_wdata_i(nvm_wdata), .nvm_ack_o(nvm_ack),
        .nvm_rdata_o(nvm_rdata), .nvm_err_o(nvm_err), .buf_addr_i(buf_addr), .buf_rdata_o(buf_rdata),
        .buf_wr_i(buf_wr), .buf_wdata_i(buf_wdata));

    always @(posedge clock_i)
    begin
        if (soft_reset === 1'b1)
            n_reset++;
        if (commit === 1'b1)
            n_commit++;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock_i);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a);
        @(posedge clock_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock_i);
        reg_rd <= 1'b0;
        #1;
        val = reg_rdata;
    endtask : rd

    // Polls the pending bit; a transfer that never ends is a failure, not a hang.
    task automatic wait_idle();
        for (int i = 0; i < 3000; i++)
        begin
            rd(12'hb00);
            if (val[0] === 1'b0)
                return;
        end
        mismatches++;
        $display("BAD pending expected 0 seen 1");
        results();
    endtask : wait_idle

    initial
    begin
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            rd(ra[i]);
            chk($sformatf("reset reg %h", ra[i]), val, re[i]);
        end
        wr(12'h234, 8'h01);
        repeat (2) @(posedge clock_i);
        chk("commit pulses", 16'(n_commit), 16'h0001);
        rd(12'h234);
        chk("commit bit", val, 8'h00);
        wr(12'hb03, 8'h01);
        rd(12'hb00);
        chk("protected pending", val, 8'h00);
        wait_idle();
        chk("protected memory", u_far.mem[0], 8'h00);
        $display("test reset and protection done");

        wr(12'h232, 8'h10);
        wr(12'hb02, 8'h01);
        wr(12'hb03, 8'h01);
        rd(12'hb00);
        chk("store pending", val, 8'h01);
        chk("status pin busy", status_pin, 1'b1);
        rd(12'hb03);
        chk("store bit busy", val, 8'h01);
        wait_idle();
        rd(12'hb03);
        chk("store bit done", val, 8'h00);
        chk("status pin idle", status_pin, 1'b0);
        for (int i = 0; i < 640; i++)
            chk("stored byte", u_far.mem[i], 8'(i) ^ 8'h5a);
        $display("test store done");

        for (int i = 0; i < 1024; i++)
            u_far.bank[i] = 8'h00;
        boot_sel <= 1'b0;
        repeat (6) @(posedge clock_i);
        wr(12'hb02, 8'h03);
        wait_idle();
        chk("reload pulses", 16'(n_reset), 16'h0001);
        chk("load commit", 16'(n_commit), 16'h0002);
        for (int i = 0; i < 640; i++)
            chk("reloaded byte", u_far.bank[i], 8'(i) ^ 8'h5a);
        rd(12'hb01);
        chk("data error clean", val, 8'h00);
        rd(12'hb02);
        chk("reload bit", val & 8'h02, 8'h00);
        $display("test reload done");

        // A leading skip opcode must be stepped over before the header.
        for (int i = 0; i < 5; i++)
            wr(12'ha00 + 12'(i), seg[i]);
        u_far.mem[0] = 8'ha5;
        u_far.mem[1] = 8'h3c;
        slow <= 1'b1;
        err_inj <= 1'b1;
        wr(12'hb02, 8'h03);
        wait_idle();
        chk("segment byte 0", u_far.bank[16], 8'ha5);
        chk("segment byte 1", u_far.bank[17], 8'h3c);
        chk("past segment", u_far.bank[18], 8'h48);
        chk("no commit op", 16'(n_commit), 16'h0002);
        rd(12'hb01);
        chk("data error set", val, 8'h01);
        boot_sel <= 1'b1;
        repeat (6) @(posedge clock_i);
        wr(12'hb02, 8'h03);
        rd(12'hb00);
        chk("boot high pending", val, 8'h00);
        chk("boot high pulses", 16'(n_reset), 16'h0002);
        $display("test segments and refusal done");
        results();
    end
endmodule : cnm_nvm_xfer_ctrl_bench

`default_nettype wire
